// File: design/aap_device.sv
// Converter end: serial frame, alarm comparators, power state, dual-use pin
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// Operation
// - Reset leaves shared pin as power-down input
// - Alarm mode drives pin high on alarm
// - Alarm pin updates at sixteenth rising edge
// - Low pin in input mode powers down immediately
// - High alarm sets above T+H, clears at or below T-H
// - Low alarm sets below T-H, clears at or above T+H
// - Active flag follows alarm condition
// - Tripped flag latches until its register read
// - Powered down frames carry no valid data
// - Pin high wakes at next frame start
// - First valid data in second active frame
// - Register power-down acts at sixteenth falling edge
// - Power-down is sequence write with field 111 and bit 7 clear
// - Commands still accepted while powered down
// - Field 000 to 110 wakes at next frame
// - Host uses only one power method
// - Frame start samples channel, starts conversion
// - Word is channel address then result
// - Bits change on chip-select and clock falls
// - Host latches bit on following falling edge
// - Input bits captured on the first sixteen rising edges of a frame
// - Configuration survives any power-down
// - Other writes act at next frame start
module aap_device
  import aap_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic [CH_N*RES_W-1:0] chan_code, // Digitised code of every channel
  output logic powered_up, // Device active and converting
  aap_link_if.device lk // Serial link and shared pin
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [2:0] din_s;
    logic [2:0] pin_s;
    logic cs_l;
    logic sck_l;
    logic pin_l;
    logic [4:0] rise_n;
    logic [4:0] fall_n;
    logic [15:0] rx;
    logic [15:0] tx;
    logic dout;
    logic dout_oe;
    logic alarm;
    logic alarm_oe;
    aap_pwr_e pwr;
    logic [WAIT_W-1:0] wait_n;
    logic by_pin;
    logic fvalid;
    logic up;
    logic pend_v;
    logic [15:0] pend;
    logic pd_now;
    logic [7:0] seq;
    logic [7:0] cfg;
    logic [CH_N-1:0][7:0] thr_hi;
    logic [CH_N-1:0][7:0] thr_lo;
    logic [CH_N-1:0][7:0] hyst;
    logic [CH_N-1:0] act_hi;
    logic [CH_N-1:0] act_lo;
    logic [CH_N-1:0] trip_hi;
    logic [CH_N-1:0] trip_lo;
    logic [RES_W-1:0] result;
    logic [CH_W-1:0] chan;
  } aap_dev_s;

  aap_dev_s q;
  aap_dev_s n;

  // ==========================================================
  // Helpers
  // Bias keeps T-H from wrapping below zero on small thresholds
  function automatic logic [1:0] aap_alarm_next(
    input logic [RES_W-1:0] r,
    input logic [7:0] th,
    input logic [7:0] tl,
    input logic [7:0] hy,
    input logic [1:0] old
  );
    logic [12:0] rb;
    logic [12:0] hu;
    logic [12:0] hd;
    logic [12:0] lu;
    logic [12:0] ld;
    logic [1:0] res;
    rb = {1'b0, r} + CMP_BIAS;
    hu = {1'b0, th, 4'h0} + CMP_BIAS + {9'h000, hy[3:0]};
    hd = {1'b0, th, 4'h0} + CMP_BIAS - {9'h000, hy[3:0]};
    lu = {1'b0, tl, 4'h0} + CMP_BIAS + {9'h000, hy[7:4]};
    ld = {1'b0, tl, 4'h0} + CMP_BIAS - {9'h000, hy[7:4]};
    res = old;
    if (rb > hu)
      res[1] = 1'b1;
    else if (rb <= hd)
      res[1] = 1'b0;
    if (rb < ld)
      res[0] = 1'b1;
    else if (rb >= lu)
      res[0] = 1'b0;
    return res;
  endfunction

  function automatic logic [7:0] aap_rd_reg(input aap_dev_s s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      REG_SEQ: v = s.seq;
      REG_CFG: v = s.cfg;
      REG_ACT: v = {s.act_lo, s.act_hi};
      REG_TRIP: v = {s.trip_lo, s.trip_hi};
      default:
      begin
        if (a[6:4] == REG_THR_PAGE)
        begin
          case (a[1:0])
            THR_HI_SUB: v = s.thr_hi[a[3:2]];
            THR_LO_SUB: v = s.thr_lo[a[3:2]];
            HYST_SUB: v = s.hyst[a[3:2]];
            default: v = 8'h00;
          endcase
        end
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // Edge detection on synchronised pins
  logic cs_now;
  logic sck_now;
  logic pin_now;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [15:0] rx_new;

  assign cs_now = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_l;
  assign sck_now = (q.sck_s[1] == q.sck_s[2]) ? q.sck_s[2] : q.sck_l;
  assign pin_now = (q.pin_s[1] == q.pin_s[2]) ? q.pin_s[2] : q.pin_l;
  assign cs_fall = q.cs_l & ~cs_now;
  assign cs_rise = ~q.cs_l & cs_now;
  assign sck_rise = ~q.sck_l & sck_now & ~q.cs_l;
  assign sck_fall = q.sck_l & ~sck_now & ~q.cs_l;
  assign rx_new = {q.rx[14:0], q.din_s[2]};

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [6:0] wa;
    logic [7:0] wd;
    logic reg_up;
    logic [1:0] al;
    wa = q.pend[15:CMD_ADDR_LSB];
    wd = q.pend[7:0];
    reg_up = 1'b0;
    al = 2'b00;
    n = q;
    n.cs_s = {q.cs_s[1:0], lk.cs_n};
    n.sck_s = {q.sck_s[1:0], lk.sclk};
    n.din_s = {q.din_s[1:0], lk.din};
    // Own alarm drive must never read back as a power-down request
    n.pin_s = {q.pin_s[1:0], lk.pin_level | q.alarm_oe};
    n.cs_l = cs_now;
    n.sck_l = sck_now;
    n.pin_l = pin_now;

    if (q.pwr == AAP_PWR_WAKE)
    begin
      if (q.wait_n == '0)
        n.pwr = AAP_PWR_READY;
      else
        n.wait_n = q.wait_n - 1'b1;
    end

    if (cs_fall)
    begin
      n.rise_n = 5'h00;
      n.fall_n = 5'h00;
      n.pd_now = 1'b0;
      // Pending writes apply here, whether powered or not
      if (q.pend_v && !q.pend[CMD_RW_BIT])
      begin
        n.pend_v = 1'b0;
        case (wa)
          REG_SEQ:
          begin
            n.seq = wd;
            reg_up = (wd[SEQ_PD_LSB +: 3] != PD_FIELD_DOWN);
          end
          REG_CFG: n.cfg = wd;
          default:
          begin
            if (wa[6:4] == REG_THR_PAGE)
            begin
              case (wa[1:0])
                THR_HI_SUB: n.thr_hi[wa[3:2]] = wd;
                THR_LO_SUB: n.thr_lo[wa[3:2]] = wd;
                HYST_SUB: n.hyst[wa[3:2]] = wd;
                default: n.wait_n = n.wait_n;
              endcase
            end
          end
        endcase
      end
      n.pend_v = 1'b0;
      case (q.pwr)
        AAP_PWR_DOWN:
        begin
          // Pin wake only for pin-made sleep; mixing methods is not supported
          if ((q.by_pin && !n.cfg[CFG_ALARM_BIT] && q.pin_l) || (!q.by_pin && reg_up))
          begin
            n.pwr = AAP_PWR_WAKE;
            n.wait_n = POWERUP_LOAD;
          end
        end
        AAP_PWR_READY: n.pwr = AAP_PWR_ACTIVE;
        default: n.pwr = q.pwr;
      endcase
      n.fvalid = (q.pwr == AAP_PWR_ACTIVE);
      n.chan = n.seq[SEQ_CH_LSB +: CH_W];
      n.result = chan_code[n.chan*RES_W +: RES_W];
      if (n.fvalid)
        n.tx = {{(CHA_W-CH_W){1'b0}}, n.chan, n.result};
      else
        n.tx = 16'h0000;
      n.dout = n.tx[15];
      n.dout_oe = 1'b1;
    end

    if (sck_rise && q.rise_n < FRAME_LAST)
    begin
      n.rx = rx_new;
      n.rise_n = q.rise_n + 5'h01;
      if (n.rise_n == READ_SPLIT && rx_new[0])
      begin
        n.tx[14:7] = aap_rd_reg(q, rx_new[7:1]);
        if (rx_new[7:1] == REG_TRIP)
        begin
          n.trip_hi = '0;
          n.trip_lo = '0;
        end
      end
      if (n.rise_n == FRAME_LAST)
      begin
        n.pend = rx_new;
        n.pend_v = 1'b1;
        n.pd_now = !rx_new[CMD_RW_BIT] && rx_new[15:CMD_ADDR_LSB] == REG_SEQ
          && !rx_new[SEQ_KEEP0_BIT] && rx_new[SEQ_PD_LSB +: 3] == PD_FIELD_DOWN;
        if (q.fvalid)
        begin
          al = aap_alarm_next(q.result, q.thr_hi[q.chan], q.thr_lo[q.chan], q.hyst[q.chan],
            {q.act_hi[q.chan], q.act_lo[q.chan]});
          n.act_hi[q.chan] = al[1];
          n.act_lo[q.chan] = al[0];
          // Applied after any read clear so a new trip is never lost
          n.trip_hi[q.chan] = n.trip_hi[q.chan] | al[1];
          n.trip_lo[q.chan] = n.trip_lo[q.chan] | al[0];
        end
        n.alarm = |{n.act_hi, n.act_lo};
      end
    end

    if (sck_fall && q.fall_n < FRAME_LAST)
    begin
      n.fall_n = q.fall_n + 5'h01;
      n.tx = {q.tx[14:0], 1'b0};
      n.dout = q.tx[14];
      if (n.fall_n == FRAME_LAST)
      begin
        n.dout_oe = 1'b0;
        n.dout = 1'b0;
        if (q.pd_now)
        begin
          n.pwr = AAP_PWR_DOWN;
          n.by_pin = 1'b0;
        end
      end
    end

    if (cs_rise)
    begin
      n.dout_oe = 1'b0;
      n.dout = 1'b0;
    end

    if (!n.cfg[CFG_ALARM_BIT] && !pin_now)
    begin
      n.pwr = AAP_PWR_DOWN;
      n.by_pin = 1'b1;
    end
    n.alarm_oe = n.cfg[CFG_ALARM_BIT];
    n.up = (n.pwr == AAP_PWR_ACTIVE);
  end

  // ==========================================================
  // Registers; configuration is changed only by reset and register writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.cs_s <= 3'h7;
      q.pin_s <= 3'h7;
      q.cs_l <= 1'b1;
      q.pin_l <= 1'b1;
      q.pwr <= AAP_PWR_ACTIVE;
      q.up <= 1'b1;
      q.seq <= SEQ_RST;
      q.cfg <= CFG_RST;
      q.thr_hi <= {CH_N{THR_HI_RST}};
      q.thr_lo <= {CH_N{THR_LO_RST}};
      q.hyst <= {CH_N{HYST_RST}};
    end
    else
      q <= n;
  end

  assign lk.dout = q.dout;
  assign lk.dout_oe = q.dout_oe;
  assign lk.pin_dev_o = q.alarm;
  assign lk.pin_dev_oe = q.alarm_oe;
  assign powered_up = q.up;
endmodule

// File: design/aap_pkg.sv
// Shared constants and types for the alarm / power-down converter link
package aap_pkg;
  // ==========================================================
  // Frame and data layout
  localparam int CH_N = 4;
  localparam int CH_W = 2;
  localparam int RES_W = 12;
  localparam int CHA_W = 4;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam logic [4:0] READ_SPLIT = 5'h08;
  localparam int CMD_RW_BIT = 8;
  localparam int CMD_ADDR_LSB = 9;
  // ==========================================================
  // Device register addresses (7-bit command address)
  localparam logic [6:0] REG_SEQ = 7'h04;
  localparam logic [6:0] REG_CFG = 7'h06;
  localparam logic [6:0] REG_ACT = 7'h20;
  localparam logic [6:0] REG_TRIP = 7'h21;
  localparam logic [2:0] REG_THR_PAGE = 3'h1;
  localparam logic [1:0] THR_HI_SUB = 2'h0;
  localparam logic [1:0] THR_LO_SUB = 2'h1;
  localparam logic [1:0] HYST_SUB = 2'h2;
  // ==========================================================
  // Device field positions and reset values
  localparam int SEQ_KEEP0_BIT = 7;
  localparam int SEQ_CH_LSB = 4;
  localparam int SEQ_PD_LSB = 1;
  localparam logic [2:0] PD_FIELD_DOWN = 3'h7;
  localparam int CFG_ALARM_BIT = 0;
  localparam logic [7:0] SEQ_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] THR_HI_RST = 8'hFF;
  localparam logic [7:0] THR_LO_RST = 8'h00;
  localparam logic [7:0] HYST_RST = 8'h00;
  localparam logic [12:0] CMP_BIAS = 13'h0010;
  // ==========================================================
  // Timing
  localparam int HCLK_PERIOD_NS = 25;
  localparam int POWERUP_DELAY_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_DELAY_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
  localparam int WAIT_W = 8;
  localparam logic [WAIT_W-1:0] POWERUP_LOAD = WAIT_W'(POWERUP_CYC - 1);
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / HCLK_PERIOD_NS;
  localparam logic [3:0] HALF_LOAD = 4'(SCLK_HALF_CYC - 1);
  // ==========================================================
  // Host register map (AHB byte offsets) and fields
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_TX = 8'h04;
  localparam logic [7:0] HOST_RX = 8'h08;
  localparam logic [7:0] HOST_STAT = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_PIN_OE = 1;
  localparam int CTRL_PIN_LVL = 2;
  // ==========================================================
  // State encodings
  typedef enum logic [3:0] {
    AAP_PWR_DOWN = 4'b0001,
    AAP_PWR_WAKE = 4'b0010,
    AAP_PWR_READY = 4'b0100,
    AAP_PWR_ACTIVE = 4'b1000
  } aap_pwr_e;
  typedef enum logic [5:0] {
    AAP_HST_IDLE = 6'b000001,
    AAP_HST_LEAD = 6'b000010,
    AAP_HST_HIGH = 6'b000100,
    AAP_HST_LOW = 6'b001000,
    AAP_HST_TAIL = 6'b010000,
    AAP_HST_GAP = 6'b100000
  } aap_hst_e;
endpackage

// File: design/aap_link_if.sv
// Four-wire serial link plus the shared alarm / power-down pin
`timescale 1ns/10ps
interface aap_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic pin_dev_o;
  logic pin_dev_oe;
  logic pin_host_o;
  logic pin_host_oe;
  logic dout_line;
  logic pin_level;
  // Released data line reads low; released shared pin is pulled high
  assign dout_line = dout_oe ? dout : 1'b0;
  assign pin_level = pin_dev_oe ? pin_dev_o : (pin_host_oe ? pin_host_o : 1'b1);
  modport device (
    input cs_n, sclk, din, pin_level,
    output dout, dout_oe, pin_dev_o, pin_dev_oe
  );
  modport host (
    input dout_line, pin_level,
    output cs_n, sclk, din, pin_host_o, pin_host_oe
  );
endinterface

// File: design/aap_host.sv
// Controller end: AHB-Lite register slave that runs serial frames
`timescale 1ns/10ps
module aap_host
  import aap_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  aap_link_if.host lk // Serial link and shared pin
);
  // ==========================================================
  // State
  typedef struct packed {
    aap_hst_e st;
    logic [3:0] div;
    logic [4:0] bit_n;
    logic cs_n;
    logic sclk;
    logic din;
    logic pin_o;
    logic pin_oe;
    logic [15:0] txw;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] rxw;
    logic done;
    logic [2:0] dout_s;
    logic dout_l;
    logic [2:0] pin_s;
    logic pin_l;
    logic ap_v;
    logic ap_w;
    logic [7:0] ap_a;
    logic [31:0] rdata;
    logic rdy;
  } aap_hst_s;

  aap_hst_s q;
  aap_hst_s n;
  logic start_req;

  assign start_req = q.ap_v && q.ap_w && q.ap_a == HOST_CTRL && hwdata[CTRL_START];

  // ==========================================================
  // Next state
  always_comb
  begin
    n = q;
    n.rdy = 1'b1;
    n.dout_s = {q.dout_s[1:0], lk.dout_line};
    n.pin_s = {q.pin_s[1:0], lk.pin_level};
    if (q.dout_s[1] == q.dout_s[2])
      n.dout_l = q.dout_s[2];
    if (q.pin_s[1] == q.pin_s[2])
      n.pin_l = q.pin_s[2];

    n.ap_v = hsel && htrans[1] && hready;
    if (n.ap_v)
    begin
      n.ap_w = hwrite;
      n.ap_a = haddr[7:0];
      if (!hwrite)
      begin
        case (haddr[7:0])
          HOST_CTRL: n.rdata = {29'h0, q.pin_o, q.pin_oe, 1'b0};
          HOST_TX: n.rdata = {16'h0000, q.txw};
          HOST_RX: n.rdata = {16'h0000, q.rxw};
          HOST_STAT: n.rdata = {29'h0, q.pin_l, q.done, q.st != AAP_HST_IDLE};
          default: n.rdata = 32'h0000_0000;
        endcase
        if (haddr[7:0] == HOST_STAT)
          n.done = 1'b0;
      end
    end
    if (q.ap_v && q.ap_w)
    begin
      // Software picks one power method; the pin is driven only when told
      if (q.ap_a == HOST_CTRL)
      begin
        n.pin_oe = hwdata[CTRL_PIN_OE];
        n.pin_o = hwdata[CTRL_PIN_LVL];
      end
      if (q.ap_a == HOST_TX)
        n.txw = hwdata[15:0];
    end

    case (q.st)
      AAP_HST_IDLE:
      begin
        if (start_req)
        begin
          n.cs_n = 1'b0;
          n.tx = q.txw;
          n.din = q.txw[15];
          n.bit_n = 5'h00;
          n.div = HALF_LOAD;
          n.st = AAP_HST_LEAD;
        end
      end
      default:
      begin
        if (q.div != 4'h0)
          n.div = q.div - 4'h1;
        else
        begin
          n.div = HALF_LOAD;
          case (q.st)
            AAP_HST_LEAD:
            begin
              n.sclk = 1'b1;
              n.st = AAP_HST_HIGH;
            end
            AAP_HST_HIGH:
            begin
              n.rx = {q.rx[14:0], q.dout_l};
              n.sclk = 1'b0;
              n.bit_n = q.bit_n + 5'h01;
              if (n.bit_n == FRAME_LAST)
                n.st = AAP_HST_TAIL;
              else
              begin
                n.tx = {q.tx[14:0], 1'b0};
                n.din = q.tx[14];
                n.st = AAP_HST_LOW;
              end
            end
            AAP_HST_LOW:
            begin
              n.sclk = 1'b1;
              n.st = AAP_HST_HIGH;
            end
            AAP_HST_TAIL:
            begin
              n.cs_n = 1'b1;
              n.din = 1'b0;
              n.rxw = q.rx;
              n.done = 1'b1;
              n.st = AAP_HST_GAP;
            end
            default: n.st = AAP_HST_IDLE;
          endcase
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.st <= AAP_HST_IDLE;
      q.cs_n <= 1'b1;
      q.pin_s <= 3'h7;
      q.pin_l <= 1'b1;
      q.rdy <= 1'b1;
    end
    else
      q <= n;
  end

  assign hreadyout = q.rdy;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;
  assign lk.cs_n = q.cs_n;
  assign lk.sclk = q.sclk;
  assign lk.din = q.din;
  assign lk.pin_host_o = q.pin_o;
  assign lk.pin_host_oe = q.pin_oe;
endmodule

// File: verification/aap_link_asserts.sv
// Concurrent checks on the converter link and the shared pin
`timescale 1ns/10ps
module aap_link_asserts (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Reset, active low
  input wire logic cs_n, // Frame select
  input wire logic sclk, // Link clock
  input wire logic dout, // Device data
  input wire logic dout_oe, // Device data enable
  input wire logic pin_dev_o, // Device pin value
  input wire logic pin_dev_oe, // Device pin enable
  input wire logic pin_level, // Resolved shared pin
  input wire logic powered_up // Device active
);
  // ==========================================================
  // Edge counters seen from the system clock
  logic cs_q, sclk_q, bad_q, seen_q;
  logic [4:0] rise_q, fall_q;
  logic [3:0] since_q;
  logic cs_fall, sck_rise, sck_fall;
  assign cs_fall = cs_q && !cs_n;
  assign sck_rise = !cs_n && sclk && !sclk_q;
  assign sck_fall = !cs_n && !sclk && sclk_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      bad_q <= 1'b0;
      seen_q <= 1'b0;
      rise_q <= 5'h00;
      fall_q <= 5'h00;
      since_q <= 4'h0;
    end
    else
    begin
      cs_q <= cs_n;
      sclk_q <= sclk;
      // A frame counts as dead when the device was not yet active at its start
      bad_q <= cs_fall ? !powered_up : bad_q;
      seen_q <= seen_q || cs_fall;
      rise_q <= cs_fall ? 5'h00 : rise_q + 5'(sck_rise);
      fall_q <= cs_fall ? 5'h00 : fall_q + 5'(sck_fall);
      // Saturates so long idle spans cannot wrap into a false match
      since_q <= (cs_fall || sck_fall) ? 4'h0 : since_q + 4'(since_q != 4'hF);
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Assertions
  pin_input_a: assert property (
    !seen_q |-> !pin_dev_oe)
    else $error("shared pin driven before any frame");
  alarm_edge_a: assert property (
    $changed(pin_dev_o) |-> !cs_n && rise_q == 5'h10)
    else $error("alarm pin moved away from the sixteenth rising edge");
  pin_sleep_a: assert property (
    !pin_dev_oe && !pin_level |-> ##[1:5] !powered_up)
    else $error("low pin did not power the device down");
  reg_sleep_a: assert property (
    $fell(powered_up) && pin_level |-> fall_q == 5'h10 && since_q <= 4'h7)
    else $error("register power-down away from the sixteenth falling edge");
  wake_frame_a: assert property (
    $rose(powered_up) |-> !cs_n && fall_q == 5'h00 && since_q <= 4'h7)
    else $error("device became active away from a frame start");
  dead_frame_a: assert property (
    bad_q && !cs_n && fall_q < 5'h08 && (fall_q != 5'h00 || since_q > 4'h7) |-> !dout)
    else $error("data driven in a frame begun while asleep");
  dout_edge_a: assert property (
    !cs_n && !$past(cs_n) && dout_oe && $past(dout_oe) && $changed(dout) |-> since_q <= 4'h7)
    else $error("data changed away from a falling edge");
  pin_mode_a: assert property (
    $changed(pin_dev_oe) |-> !cs_n && fall_q == 5'h00 && since_q <= 4'h7)
    else $error("pin mode changed away from a frame start");
  alarm_rise_c: cover property ($rose(pin_dev_o));
  reg_sleep_c: cover property ($fell(powered_up) && pin_level);
  wake_c: cover property ($rose(powered_up));
endmodule

// File: verification/adc_alarm_powerdown_frame_tb_top.sv
// Testbench: controller and converter ends joined over the serial link
`timescale 1ns/10ps
module adc_alarm_powerdown_frame_tb_top
  import aap_pkg::*;
;
  // ==========================================================
  // Stimulus state
  localparam logic [15:0] NOP = 16'hFE00;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [47:0] chan_code = 48'hE749635A23C1;
  logic pin_oe = 1'b0;
  logic pin_lvl = 1'b1;
  logic hreadyout, hresp, powered_up;
  logic [31:0] hrdata, rd;
  logic [15:0] rx;
  int err_count = 0;
  int check_count = 0;
  logic [11:0] al_code [6] = '{12'h801, 12'h800, 12'h3FF, 12'h400, 12'h400, 12'h400};
  logic [6:0] al_reg [6] = '{REG_ACT, REG_ACT, REG_ACT, REG_TRIP, REG_TRIP, REG_ACT};
  logic [7:0] al_flag [6] = '{8'h00, 8'h01, 8'h00, 8'h11, 8'h00, 8'h00};
  logic [5:0] al_pin = 6'h05;
  always #12.5 hclk = ~hclk;
  // ==========================================================
  // Both ends and the checker
  aap_link_if u_aap_link_if ();
  aap_device u_aap_device (.hclk(hclk), .hresetn(hresetn), .chan_code(chan_code),
    .powered_up(powered_up), .lk(u_aap_link_if));
  aap_host u_aap_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lk(u_aap_link_if));
  aap_link_asserts u_aap_link_asserts (.hclk(hclk), .hresetn(hresetn),
    .cs_n(u_aap_link_if.cs_n), .sclk(u_aap_link_if.sclk), .dout(u_aap_link_if.dout),
    .dout_oe(u_aap_link_if.dout_oe), .pin_dev_o(u_aap_link_if.pin_dev_o),
    .pin_dev_oe(u_aap_link_if.pin_dev_oe), .pin_level(u_aap_link_if.pin_level),
    .powered_up(powered_up));
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pwr(input logic e);
    chk("powered_up", {31'h0, powered_up}, {31'h0, e});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  // Runs one link frame and returns the word the device sent in it
  task automatic frame(input logic [15:0] tx, output logic [15:0] rxw);
    logic [31:0] st;
    int n;
    bus(1'b1, HOST_TX, {16'h0000, tx}, st);
    bus(1'b1, HOST_CTRL, {29'h0, pin_lvl, pin_oe, 1'b1}, st);
    st = 32'h00000000;
    n = 0;
    while (st[1] !== 1'b1 && n < 400)
    begin
      bus(1'b0, HOST_STAT, 32'h0, st);
      n++;
    end
    chk("frame done", {31'h0, st[1]}, 32'h1);
    bus(1'b0, HOST_RX, 32'h0, st);
    rxw = st[15:0];
    // The controller ignores a start until its inter-frame gap has run out
    repeat (10) @(posedge hclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("pin enable", {31'h0, u_aap_link_if.pin_dev_oe}, 32'h0);
    pwr(1'b1);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped read", rd, 32'h0);
    chk("bus response", {31'h0, hresp}, 32'h0);
    chk("bus ready", {31'h0, hreadyout}, 32'h1);
    for (int c = 1; c <= 4; c++)
    begin
      frame({REG_SEQ, 1'b0, 2'h0, 2'(c % 4), 4'h0}, rx);
      chk("channel word", {16'h0, rx}, {18'h0, 2'(c - 1), chan_code[(c - 1) * 12 +: 12]});
    end
    frame({REG_CFG, 1'b0, 8'h01}, rx);
    frame({REG_THR_PAGE, 2'h0, THR_HI_SUB, 1'b0, 8'h80}, rx);
    frame({REG_THR_PAGE, 2'h0, THR_LO_SUB, 1'b0, 8'h40}, rx);
    for (int i = 0; i < 6; i++)
    begin
      chan_code[11:0] <= al_code[i];
      frame({al_reg[i], 1'b1, 8'h00}, rx);
      chk("alarm flags", {16'h0, rx}, {20'h0, al_code[i][11:8], al_flag[i]});
      chk("alarm pin", {31'h0, u_aap_link_if.pin_level}, {31'h0, al_pin[i]});
    end
    frame({REG_CFG, 1'b0, 8'h00}, rx);
    frame({REG_SEQ, 1'b0, 8'h8E}, rx);
    pwr(1'b1);
    for (int f = 0; f < 7; f++)
    begin
      frame({REG_SEQ, 1'b0, 8'h0E}, rx);
      pwr(1'b0);
      frame({REG_SEQ, 1'b0, 4'h0, 3'(f), 1'b0}, rx);
      chk("asleep word", {16'h0, rx}, 32'h0);
      frame(NOP, rx);
      chk("waking word", {16'h0, rx}, 32'h0);
      frame(NOP, rx);
      chk("first active word", {16'h0, rx}, 32'h0);
      pwr(1'b1);
      frame(NOP, rx);
      chk("first valid word", {16'h0, rx}, {20'h0, chan_code[11:0]});
    end
    frame({REG_THR_PAGE, 2'h0, THR_HI_SUB, 1'b1, 8'h00}, rx);
    chk("kept threshold", {16'h0, rx}, {20'h0, chan_code[11:8], 8'h80});
    pin_oe = 1'b1;
    pin_lvl = 1'b0;
    bus(1'b1, HOST_CTRL, 32'h2, rd);
    repeat (6) @(posedge hclk);
    pwr(1'b0);
    bus(1'b0, HOST_STAT, 32'h0, rd);
    chk("pin level status", rd & 32'h4, 32'h0);
    bus(1'b0, HOST_CTRL, 32'h0, rd);
    chk("control readback", rd, 32'h2);
    frame(NOP, rx);
    chk("pin asleep word", {16'h0, rx}, 32'h0);
    pin_lvl = 1'b1;
    bus(1'b1, HOST_CTRL, 32'h6, rd);
    repeat (6) @(posedge hclk);
    frame(NOP, rx);
    chk("pin waking word", {16'h0, rx}, 32'h0);
    frame(NOP, rx);
    chk("pin active word", {16'h0, rx}, 32'h0);
    pwr(1'b1);
    frame(NOP, rx);
    chk("pin valid word", {16'h0, rx}, {20'h0, chan_code[11:0]});
    final_report;
  end
  // A hang ends the run through the same closing task
  initial
  begin
    repeat (60000) @(posedge hclk);
    err_count++;
    $display("FAIL watchdog expected finish seen timeout");
    final_report;
  end
endmodule
